/* File: hw/smc_link_rx.sv */
module smc_link_rx
	import smc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic processor_activity_link,
	output logic gfx_access
);
	logic link_meta;
	logic link_s;
	logic busy;
	logic [7:0] bit_timer;
	logic [2:0] bit_index;
	logic [LINK_CLASS_BITS-1:0] classes;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			link_meta <= 1'b1;
			link_s <= 1'b1;
		end else begin
			link_meta <= processor_activity_link;
			link_s <= link_meta;
		end
	end

	// idle high, start low, then one bit per class: vga regs, vga fb, accel regs, configured fb
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			busy <= 1'b0;
			bit_timer <= 8'h00;
			bit_index <= 3'h0;
			classes <= '0;
			gfx_access <= 1'b0;
		end else begin
			gfx_access <= 1'b0;
			if (!busy) begin
				if (!link_s) begin
					busy <= 1'b1;
					bit_timer <= 8'(LINK_BIT_CYCLES + LINK_BIT_CYCLES / 2 - 1);
					bit_index <= 3'h0;
				end
			end else if (bit_timer != 8'h00) begin
				bit_timer <= bit_timer - 8'h01;
			end else begin
				classes <= {link_s, classes[LINK_CLASS_BITS-1:1]};
				bit_timer <= 8'(LINK_BIT_CYCLES - 1);
				if (bit_index == 3'(LINK_CLASS_BITS - 1)) begin
					busy <= 1'b0;
					gfx_access <= link_s | (|classes[LINK_CLASS_BITS-1:1]);
				end else begin
					bit_index <= bit_index + 3'h1;
				end
			end
		end
	end
endmodule

/* File: hw/smc_pkg.sv */
package smc_pkg;
	localparam int CLK_MHZ = 125;
	localparam int INTERVAL_US = 32;
	localparam int INTERVAL_CYCLES = INTERVAL_US * CLK_MHZ;
	localparam int MS_US = 1000;
	localparam int MS_CYCLES = MS_US * CLK_MHZ;
	localparam int LINK_BIT_CYCLES = 4;
	localparam int LINK_CLASS_BITS = 4;

	localparam logic [7:0] OFS_POWER_MGMT_ENABLE_ONE = 8'h80;
	localparam logic [7:0] OFS_IRQ_SPEEDUP_COUNT = 8'h8C;
	localparam logic [7:0] OFS_VIDEO_SPEEDUP_COUNT = 8'h8D;
	localparam logic [7:0] OFS_THROTTLE_RELEASE_COUNT = 8'h94;
	localparam logic [7:0] OFS_THROTTLE_ASSERT_COUNT = 8'h95;
	localparam logic [7:0] OFS_SUSPEND_CONFIG = 8'h96;
	localparam logic [7:0] OFS_CLOCK_STOP_CONTROL = 8'hBC;
	localparam logic [7:0] OFS_SEQUENCER_STATUS = 8'hBE;

	localparam logic [7:0] RST_REG = 8'h00;

	localparam int BIT_IRQ_SPEEDUP_EN = 3;
	localparam int BIT_VIDEO_SPEEDUP_EN = 4;
	localparam int BIT_THROTTLE_EN = 0;
	localparam int BIT_SMI_SPEEDUP_CFG = 1;
	localparam int BIT_FULL_CLOCK_STOP_SELECT = 0;
	localparam int LOCK_DELAY_LSB = 4;
	localparam logic [7:0] CLOCK_STOP_CONTROL_MASK = 8'hF1;
	localparam logic [7:0] SUSPEND_CONFIG_MASK = 8'h1F;

	localparam logic [15:0] VGA_IO_MASK = 16'hFFF0;
	localparam logic [15:0] VGA_IO_MONO = 16'h03B0;
	localparam logic [15:0] VGA_IO_COLOR_A = 16'h03C0;
	localparam logic [15:0] VGA_IO_COLOR_B = 16'h03D0;
	localparam logic [31:0] VGA_MEM_LOW = 32'h000A0000;
	localparam logic [31:0] VGA_MEM_HIGH = 32'h000B7FFF;

	typedef enum logic [1:0] {
		SMC_CPU_SUSPEND_REQUEST_N_IDLE = 2'b00,
		SMC_CPU_SUSPEND_REQUEST_N_REQ = 2'b01,
		SMC_CPU_SUSPEND_REQUEST_N_HELD = 2'b11,
		SMC_CPU_SUSPEND_REQUEST_N_LOCK = 2'b10
	} smc_cpu_suspend_request_n_t;
endpackage

/* File: hw/smc_sequencer.sv */
module smc_sequencer
	import smc_pkg::*;
#(
	parameter int MS_TICK_CYCLES = smc_pkg::MS_CYCLES,
	parameter int VIDEO_TICK_CYCLES = smc_pkg::MS_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	input wire logic suspend_cmd_wr,
	input wire logic smi_speedup_disable_rd,
	input wire logic irq_unmasked,
	input wire logic port061_access,
	input wire logic smi_event,
	input wire logic pci_io_access,
	input wire logic [15:0] pci_io_addr,
	input wire logic pci_mem_access,
	input wire logic [31:0] pci_mem_addr,
	input wire logic processor_activity_link,
	input wire logic cpu_suspend_ack_n,
	output logic cpu_suspend_request_n,
	output logic system_mgmt_interrupt_n,
	input wire logic deep_suspend_clock_gate_in,
	output logic deep_suspend_clock_gate_out,
	output logic deep_suspend_clock_gate_oe
);
	import smc_pkg::*;

	logic [7:0] power_mgmt_enable_one;
	logic [7:0] irq_speedup_count;
	logic [7:0] video_speedup_count;
	logic [7:0] throttle_release_count;
	logic [7:0] throttle_assert_count;
	logic [7:0] suspend_config;
	logic [7:0] clock_stop_control;

	logic tick_32us;
	logic tick_ms;
	logic tick_video;
	logic link_gfx;
	logic ack_meta;
	logic ack_n_s;
	logic gate_meta;
	logic gate_s;
	logic gate_inactive;

	smc_cpu_suspend_request_n_t cpu_suspend_request_n_state;
	logic [3:0] lock_ms;
	logic [7:0] irq_timer;
	logic [7:0] video_timer;
	logic smi_hold;
	logic mod_phase_assert;
	logic [7:0] mod_count;

	logic throttle_en;
	logic break_event;
	logic pci_vga;
	logic irq_load;
	logic video_load;
	logic speedup_event;
	logic speedup_active;
	logic full_stop;

	smc_tick #(.CYCLES(INTERVAL_CYCLES)) u_tick_32us (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.tick(tick_32us)
	);

	smc_tick #(.CYCLES(MS_TICK_CYCLES)) u_tick_ms (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.tick(tick_ms)
	);

	smc_tick #(.CYCLES(VIDEO_TICK_CYCLES)) u_tick_video (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.tick(tick_video)
	);

	smc_link_rx u_link_rx (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.processor_activity_link(processor_activity_link),
		.gfx_access(link_gfx)
	);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ack_meta <= 1'b1;
			ack_n_s <= 1'b1;
		end else begin
			ack_meta <= cpu_suspend_ack_n;
			ack_n_s <= ack_meta;
		end
	end

	// no reset here: the pin level must travel through while reset is held
	always_ff @(posedge clk_sys) begin
		gate_meta <= deep_suspend_clock_gate_in;
		gate_s <= gate_meta;
	end

	// pin is an input throughout reset, so the pull resistor sets the level we learn
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			gate_inactive <= gate_s;
		end
	end

	// register writes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			power_mgmt_enable_one <= RST_REG;
			irq_speedup_count <= RST_REG;
			video_speedup_count <= RST_REG;
			throttle_release_count <= RST_REG;
			throttle_assert_count <= RST_REG;
			suspend_config <= RST_REG;
			clock_stop_control <= RST_REG;
		end else if (cfg_wr) begin
			case (cfg_index)
				OFS_POWER_MGMT_ENABLE_ONE: power_mgmt_enable_one <= cfg_wdata;
				OFS_IRQ_SPEEDUP_COUNT: irq_speedup_count <= cfg_wdata;
				OFS_VIDEO_SPEEDUP_COUNT: video_speedup_count <= cfg_wdata;
				OFS_THROTTLE_RELEASE_COUNT: throttle_release_count <= cfg_wdata;
				OFS_THROTTLE_ASSERT_COUNT: throttle_assert_count <= cfg_wdata;
				OFS_SUSPEND_CONFIG: suspend_config <= cfg_wdata & SUSPEND_CONFIG_MASK;
				OFS_CLOCK_STOP_CONTROL: clock_stop_control <= cfg_wdata & CLOCK_STOP_CONTROL_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cfg_rdata <= 8'h00;
		end else if (cfg_rd) begin
			case (cfg_index)
				OFS_POWER_MGMT_ENABLE_ONE: cfg_rdata <= power_mgmt_enable_one;
				OFS_IRQ_SPEEDUP_COUNT: cfg_rdata <= irq_speedup_count;
				OFS_VIDEO_SPEEDUP_COUNT: cfg_rdata <= video_speedup_count;
				OFS_THROTTLE_RELEASE_COUNT: cfg_rdata <= throttle_release_count;
				OFS_THROTTLE_ASSERT_COUNT: cfg_rdata <= throttle_assert_count;
				OFS_SUSPEND_CONFIG: cfg_rdata <= suspend_config;
				OFS_CLOCK_STOP_CONTROL: cfg_rdata <= clock_stop_control;
				OFS_SEQUENCER_STATUS: cfg_rdata <= {2'b00, cpu_suspend_request_n_state, smi_hold, |video_timer, |irq_timer,
					mod_phase_assert};
				default: cfg_rdata <= 8'h00;
			endcase
		end
	end

	// only irq, port 061h, smi and graphics feed speedup; bus master requests have no input here
	always_comb begin
		throttle_en = suspend_config[BIT_THROTTLE_EN];
		full_stop = clock_stop_control[BIT_FULL_CLOCK_STOP_SELECT];
		break_event = irq_unmasked | smi_event;
		pci_vga = (pci_io_access && ((pci_io_addr & VGA_IO_MASK) == VGA_IO_MONO
			|| (pci_io_addr & VGA_IO_MASK) == VGA_IO_COLOR_A
			|| (pci_io_addr & VGA_IO_MASK) == VGA_IO_COLOR_B))
			|| (pci_mem_access && pci_mem_addr >= VGA_MEM_LOW && pci_mem_addr <= VGA_MEM_HIGH);
		irq_load = throttle_en && power_mgmt_enable_one[BIT_IRQ_SPEEDUP_EN]
			&& (irq_unmasked || port061_access
			|| (smi_event && !suspend_config[BIT_SMI_SPEEDUP_CFG]));
		video_load = throttle_en && power_mgmt_enable_one[BIT_VIDEO_SPEEDUP_EN]
			&& (link_gfx || pci_vga);
		speedup_event = irq_load | video_load;
		speedup_active = (irq_timer != 8'h00) || (video_timer != 8'h00) || smi_hold;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_timer <= 8'h00;
		end else if (irq_load) begin
			irq_timer <= irq_speedup_count;
		end else if (tick_ms && irq_timer != 8'h00) begin
			irq_timer <= irq_timer - 8'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			video_timer <= 8'h00;
		end else if (video_load) begin
			video_timer <= video_speedup_count;
		end else if (tick_video && video_timer != 8'h00) begin
			video_timer <= video_timer - 8'h01;
		end
	end

	// the smi that sets the hold wins over a disable read in the same cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			smi_hold <= 1'b0;
		end else if (!throttle_en) begin
			smi_hold <= 1'b0;
		end else if (smi_event && suspend_config[BIT_SMI_SPEEDUP_CFG]) begin
			smi_hold <= 1'b1;
		end else if (smi_speedup_disable_rd) begin
			smi_hold <= 1'b0;
		end
	end

	// modulation: release phase then assert phase, each counted in 32 us intervals
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mod_phase_assert <= 1'b0;
			mod_count <= 8'h00;
		end else if (!throttle_en || speedup_active || speedup_event) begin
			mod_phase_assert <= 1'b0;
			mod_count <= 8'h00;
		end else if (tick_32us) begin
			if (mod_phase_assert) begin
				if (mod_count + 8'h01 >= throttle_assert_count) begin
					mod_phase_assert <= 1'b0;
					mod_count <= 8'h00;
				end else begin
					mod_count <= mod_count + 8'h01;
				end
			end else if (mod_count + 8'h01 >= throttle_release_count) begin
				mod_phase_assert <= throttle_assert_count != 8'h00;
				mod_count <= 8'h00;
			end else begin
				mod_count <= mod_count + 8'h01;
			end
		end
	end

	// software suspend; the lock delay counts whole 1 ms ticks, first one may be short
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cpu_suspend_request_n_state <= SMC_CPU_SUSPEND_REQUEST_N_IDLE;
			lock_ms <= 4'h0;
		end else begin
			case (cpu_suspend_request_n_state)
				SMC_CPU_SUSPEND_REQUEST_N_IDLE: begin
					if (suspend_cmd_wr) begin
						cpu_suspend_request_n_state <= SMC_CPU_SUSPEND_REQUEST_N_REQ;
					end
				end
				SMC_CPU_SUSPEND_REQUEST_N_REQ: begin
					if (break_event) begin
						cpu_suspend_request_n_state <= SMC_CPU_SUSPEND_REQUEST_N_IDLE;
					end else if (!ack_n_s) begin
						cpu_suspend_request_n_state <= SMC_CPU_SUSPEND_REQUEST_N_HELD;
					end
				end
				SMC_CPU_SUSPEND_REQUEST_N_HELD: begin
					if (break_event) begin
						if (full_stop) begin
							cpu_suspend_request_n_state <= SMC_CPU_SUSPEND_REQUEST_N_LOCK;
							lock_ms <= clock_stop_control[LOCK_DELAY_LSB +: 4];
						end else begin
							cpu_suspend_request_n_state <= SMC_CPU_SUSPEND_REQUEST_N_IDLE;
						end
					end
				end
				SMC_CPU_SUSPEND_REQUEST_N_LOCK: begin
					if (lock_ms == 4'h0) begin
						cpu_suspend_request_n_state <= SMC_CPU_SUSPEND_REQUEST_N_IDLE;
					end else if (tick_ms) begin
						lock_ms <= lock_ms - 4'h1;
					end
				end
				default: cpu_suspend_request_n_state <= SMC_CPU_SUSPEND_REQUEST_N_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cpu_suspend_request_n <= 1'b1;
			system_mgmt_interrupt_n <= 1'b1;
			deep_suspend_clock_gate_out <= 1'b0;
			deep_suspend_clock_gate_oe <= 1'b0;
		end else begin
			cpu_suspend_request_n <= !(cpu_suspend_request_n_state != SMC_CPU_SUSPEND_REQUEST_N_IDLE || mod_phase_assert);
			system_mgmt_interrupt_n <= cpu_suspend_request_n_state != SMC_CPU_SUSPEND_REQUEST_N_LOCK;
			deep_suspend_clock_gate_oe <= 1'b1;
			deep_suspend_clock_gate_out <= (cpu_suspend_request_n_state == SMC_CPU_SUSPEND_REQUEST_N_HELD && full_stop && !break_event)
				? !gate_inactive : gate_inactive;
		end
	end
endmodule

/* File: hw/smc_tick.sv */
module smc_tick #(
	parameter int CYCLES = 4000
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	output logic tick
);
	logic [31:0] count;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			count <= 32'h00000000;
			tick <= 1'b0;
		end else if (count == 32'(CYCLES - 1)) begin
			count <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			count <= count + 32'h00000001;
			tick <= 1'b0;
		end
	end
endmodule

/* File: tb/smc_host_model.sv */
module smc_host_model #(
	parameter int ACK_DLY = 3
) (
	input wire logic clk_sys,
	input wire logic cpu_suspend_request_n,
	output logic cpu_suspend_ack_n,
	output logic processor_activity_link
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	initial cpu_suspend_ack_n = 1'b1;
	initial processor_activity_link = 1'b1;
	// halt entry and exit both take a few cycles
	always @(posedge clk_sys) begin
		n <= (cpu_suspend_ack_n == cpu_suspend_request_n) ? 0 : n + 1;
		if (n == ACK_DLY)
			cpu_suspend_ack_n <= cpu_suspend_request_n;
	end
	task automatic send_class(input logic [3:0] cls);
		logic [4:0] fr;
		fr = {cls, 1'b0};
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_sys);
			processor_activity_link <= fr[i];
			repeat (smc_pkg::LINK_BIT_CYCLES - 1) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		processor_activity_link <= 1'b1;
	endtask
endmodule

/* File: tb/smc_sequencer_props.sv */
module smc_sequencer_props #(
	parameter int MS_TICK_CYCLES = 20,
	parameter int VIDEO_TICK_CYCLES = 20
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	input wire logic suspend_cmd_wr,
	input wire logic irq_unmasked,
	input wire logic smi_event,
	input wire logic cpu_suspend_ack_n,
	input wire logic cpu_suspend_request_n,
	input wire logic system_mgmt_interrupt_n,
	input wire logic deep_suspend_clock_gate_in,
	input wire logic deep_suspend_clock_gate_out,
	input wire logic deep_suspend_clock_gate_oe
);
	logic [7:0] bc;
	logic mod_en;
	logic idle_lvl;
	int lock_n;
	wire act = deep_suspend_clock_gate_oe && deep_suspend_clock_gate_out != idle_lvl;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bc <= 8'h00;
			mod_en <= 1'b0;
		end else if (cfg_wr && cfg_index == 8'hBC) begin
			bc <= cfg_wdata;
		end else if (cfg_wr && cfg_index == 8'h96) begin
			mod_en <= cfg_wdata[0];
		end
	end
	// pin level while undriven in reset is the idle level
	always_ff @(posedge clk_sys) if (sys_rst) idle_lvl <= deep_suspend_clock_gate_in;
	always_ff @(posedge clk_sys) lock_n <= (sys_rst || system_mgmt_interrupt_n) ? 0 : lock_n + 1;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	property p_cmd;
		suspend_cmd_wr && !mod_en && cpu_suspend_request_n && system_mgmt_interrupt_n && !$past(suspend_cmd_wr)
			|-> ##[2:3] !cpu_suspend_request_n;
	endproperty
	a_cmd: assert property (p_cmd) else $error("no suspend request after command");
	property p_lock;
		!system_mgmt_interrupt_n |-> !cpu_suspend_request_n && lock_n <= bc[7:4] * MS_TICK_CYCLES + 4;
	endproperty
	a_lock: assert property (p_lock) else $error("lock delay too long or request released");
	property p_full;
		$fell(system_mgmt_interrupt_n) |-> bc[0];
	endproperty
	a_full: assert property (p_full) else $error("lock delay without full stop");
	property p_gate_on;
		$rose(act) |-> bc[0] && !$past(cpu_suspend_ack_n, 2);
	endproperty
	a_gate_on: assert property (p_gate_on) else $error("clock gate before handshake");
	property p_gate_req;
		act |-> !cpu_suspend_request_n && system_mgmt_interrupt_n;
	endproperty
	a_gate_req: assert property (p_gate_req) else $error("clock gate with request released");
	property p_break;
		act && (irq_unmasked || smi_event) |-> ##[1:3] !act && !system_mgmt_interrupt_n;
	endproperty
	a_break: assert property (p_break) else $error("break did not open clock gate");
	property p_rel;
		irq_unmasked && !bc[0] && !mod_en && !cpu_suspend_request_n |-> ##[1:3] cpu_suspend_request_n;
	endproperty
	a_rel: assert property (p_rel) else $error("interrupt did not release request");
	property p_oe;
		deep_suspend_clock_gate_oe |=> deep_suspend_clock_gate_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("clock gate driver dropped");
	c_cmd: cover property (suspend_cmd_wr);
	c_gate: cover property ($rose(act));
	c_lock: cover property ($fell(system_mgmt_interrupt_n));
endmodule

bind smc_sequencer smc_sequencer_props #(.MS_TICK_CYCLES(MS_TICK_CYCLES), .VIDEO_TICK_CYCLES(VIDEO_TICK_CYCLES))
	i_smc_sequencer_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_index(cfg_index),
	.cfg_wdata(cfg_wdata), .suspend_cmd_wr(suspend_cmd_wr), .irq_unmasked(irq_unmasked), .smi_event(smi_event),
	.cpu_suspend_ack_n(cpu_suspend_ack_n), .cpu_suspend_request_n(cpu_suspend_request_n),
	.system_mgmt_interrupt_n(system_mgmt_interrupt_n), .deep_suspend_clock_gate_in(deep_suspend_clock_gate_in),
	.deep_suspend_clock_gate_out(deep_suspend_clock_gate_out), .deep_suspend_clock_gate_oe(deep_suspend_clock_gate_oe));

/* File: tb/smc_sequencer_tb.sv */
module smc_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import smc_pkg::*;
	localparam int MS = 20;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic cfg_wr = 1'b0, cfg_rd = 1'b0, suspend_cmd_wr = 1'b0, smi_speedup_disable_rd = 1'b0;
	logic irq_unmasked = 1'b0, port061_access = 1'b0, smi_event = 1'b0, pci_io_access = 1'b0, pci_mem_access = 1'b0;
	logic [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00, cfg_rdata, d;
	logic [15:0] pci_io_addr = 16'h0000;
	logic [31:0] pci_mem_addr = 32'h00000000;
	logic link, ack_n, req_n, smi_n, gate_out, gate_oe;
	// board pull-up makes the gate idle high
	wire gate_in = gate_oe ? gate_out : 1'b1;
	int errors = 0, check_count = 0, cyc = 0, n;
	logic [7:0] regs [6] = '{8'h80, 8'h8C, 8'h8D, 8'h94, 8'h95, 8'hBC};
	smc_sequencer #(.MS_TICK_CYCLES(MS), .VIDEO_TICK_CYCLES(MS)) i_smc_sequencer (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .suspend_cmd_wr(suspend_cmd_wr), .smi_speedup_disable_rd(smi_speedup_disable_rd),
		.irq_unmasked(irq_unmasked), .port061_access(port061_access), .smi_event(smi_event),
		.pci_io_access(pci_io_access), .pci_io_addr(pci_io_addr), .pci_mem_access(pci_mem_access),
		.pci_mem_addr(pci_mem_addr), .processor_activity_link(link), .cpu_suspend_ack_n(ack_n),
		.cpu_suspend_request_n(req_n), .system_mgmt_interrupt_n(smi_n), .deep_suspend_clock_gate_in(gate_in),
		.deep_suspend_clock_gate_out(gate_out), .deep_suspend_clock_gate_oe(gate_oe));
	smc_host_model i_smc_host_model (.clk_sys(clk_sys), .cpu_suspend_request_n(req_n),
		.cpu_suspend_ack_n(ack_n), .processor_activity_link(link));
	initial forever #4 clk_sys = ~clk_sys;
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		@(negedge clk_sys);
		cfg_index = idx;
		cfg_wdata = v;
		cfg_wr = 1'b1;
		@(negedge clk_sys);
		cfg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, output logic [7:0] v);
		@(negedge clk_sys);
		cfg_index = idx;
		cfg_rd = 1'b1;
		@(negedge clk_sys);
		cfg_rd = 1'b0;
		@(negedge clk_sys);
		v = cfg_rdata;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk_sys);
		s = 1'b1;
		@(negedge clk_sys);
		s = 1'b0;
	endtask
	task automatic wait_lvl(ref logic s, input logic v, output int c);
		c = 0;
		while (s !== v && c < 30000) begin
			@(negedge clk_sys);
			c++;
		end
	endtask
	initial begin
		repeat (10) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		check("gate_oe", gate_oe, 1);
		check("gate_idle", gate_out, 1);
		foreach (regs[i]) begin
			rd(regs[i], d);
			check("reset_val", d, 0);
			wr(regs[i], 8'hA5);
			rd(regs[i], d);
			check("readback", d, regs[i] == 8'hBC ? 8'hA1 : 8'hA5);
			wr(regs[i], 8'h00);
		end
		wr(8'h81, 8'hFF);
		rd(8'h81, d);
		check("unmapped", d, 0);
		pulse(suspend_cmd_wr);
		repeat (20) @(negedge clk_sys);
		check("plain_req", req_n, 0);
		check("plain_gate", gate_out, 1);
		pulse(irq_unmasked);
		repeat (3) @(negedge clk_sys);
		check("plain_rel", req_n, 1);
		for (int dly = 0; dly < 4; dly += 3) begin
			// let the host drop its acknowledge before the next command
			repeat (10) @(negedge clk_sys);
			wr(8'hBC, {dly[3:0], 4'h1});
			pulse(suspend_cmd_wr);
			repeat (20) @(negedge clk_sys);
			check("gate_on", gate_out, 0);
			pulse(smi_event);
			@(negedge clk_sys);
			check("gate_off", gate_out, 1);
			if (dly > 0)
				check("smi_lock", smi_n, 0);
			wait_lvl(req_n, 1'b1, n);
			check("lock_len", n >= dly * MS - MS && n <= dly * MS + 6, 1);
		end
		wr(8'h80, 8'h18);
		wr(8'h8C, 8'h03);
		wr(8'h8D, 8'h32);
		wr(8'h94, 8'h01);
		wr(8'h95, 8'h02);
		wr(8'h96, 8'h01);
		wait_lvl(req_n, 1'b0, n);
		wait_lvl(req_n, 1'b1, n);
		wait_lvl(req_n, 1'b0, n);
		wait_lvl(req_n, 1'b1, n);
		check("on_len", n >= 2 * INTERVAL_CYCLES - 3 && n <= 2 * INTERVAL_CYCLES + 3, 1);
		wait_lvl(req_n, 1'b0, n);
		check("off_len", n >= INTERVAL_CYCLES - 3 && n <= INTERVAL_CYCLES + 3, 1);
		for (int k = 0; k < 7; k++) begin
			wait_lvl(req_n, 1'b0, n);
			repeat (10) @(negedge clk_sys);
			case (k)
				0: pulse(irq_unmasked);
				1: pulse(port061_access);
				2: pulse(smi_event);
				3: i_smc_host_model.send_class(4'h1);
				4: begin
					pci_io_addr = 16'h03B4;
					pulse(pci_io_access);
				end
				5: begin
					pci_mem_addr = 32'h000A0000;
					pulse(pci_mem_access);
				end
				default: begin
					pci_mem_addr = 32'h00100000;
					pulse(pci_mem_access);
				end
			endcase
			repeat (30) @(negedge clk_sys);
			check("speedup", req_n, k < 6);
			check("no_smi", smi_n, 1);
		end
		wr(8'h96, 8'h03);
		wait_lvl(req_n, 1'b0, n);
		pulse(smi_event);
		repeat (5000) @(negedge clk_sys);
		check("smi_hold", req_n, 1);
		pulse(smi_speedup_disable_rd);
		wait_lvl(req_n, 1'b0, n);
		check("rearm", n < 4200, 1);
		wrap_up();
	end
endmodule
